// ### design/can_mode_pkg.sv
`default_nettype none
package can_mode_pkg;
    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_NS = 20;

    // ------------------------------------------------------------
    // timing figures, in their own units
    // ------------------------------------------------------------
    localparam int unsigned STBY_NOM_US     = 70;
    localparam int unsigned NOM_SLP_US      = 200;
    localparam int unsigned SLP_STBY_US     = 200;
    localparam int unsigned NOM_STBY_US     = 200;
    localparam int unsigned WAKE_FILT_NS    = 1000;  // inside 0.5 .. 1.8 us
    localparam int unsigned WAKE_WIN_US     = 2000;  // inside 0.5 .. 2.9 ms
    localparam int unsigned SILENCE_MS      = 900;   // inside 0.6 .. 1.2 s
    localparam int unsigned INACTIVE_S      = 240;   // inside 2 .. 6 min
    localparam int unsigned DOM_TIMEOUT_US  = 2000;  // inside 1 .. 5 ms

    // ------------------------------------------------------------
    // derived cycle counts
    // ------------------------------------------------------------
    localparam int unsigned STBY_NOM_CYC    = STBY_NOM_US * (CLK_HZ / 1_000_000);
    localparam int unsigned NOM_SLP_CYC     = NOM_SLP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SLP_STBY_CYC    = SLP_STBY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned NOM_STBY_CYC    = NOM_STBY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WAKE_FILT_CYC   = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WAKE_WIN_CYC    = WAKE_WIN_US * (CLK_HZ / 1_000_000);
    localparam longint unsigned SILENCE_CYC = longint'(SILENCE_MS) * (CLK_HZ / 1000);
    localparam longint unsigned INACTIVE_CYC = longint'(INACTIVE_S) * CLK_HZ;
    localparam int unsigned DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);

    // ------------------------------------------------------------
    // modes and commands
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_NORMAL
    } mode_t;

    localparam logic [1:0] CMD_SLEEP   = 2'h0;
    localparam logic [1:0] CMD_STANDBY = 2'h1;
    localparam logic [1:0] CMD_NORMAL  = 2'h2;
endpackage : can_mode_pkg
`default_nettype wire

// ### design/wake_pattern_detect.sv
`default_nettype none
module wake_pattern_detect #(
    parameter int unsigned FILT_CYC = 50,
    parameter int unsigned WIN_CYC  = 100000
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic enable_i,
    input  wire logic bus_dom_i,
    output logic      bus_wake_pattern_o
);
    import can_mode_pkg::*;

    // ------------------------------------------------------------
    // filter: a phase counts once held FILT_CYC cycles
    // ------------------------------------------------------------
    typedef enum {
        WP_IDLE,
        WP_DOM1,
        WP_REC,
        WP_DOM2
    } wp_state_t;

    wp_state_t        st_q;
    logic [31:0]      hold_q;
    logic [31:0]      win_q;
    logic             last_q;
    logic             filt_ok;

    assign filt_ok = (hold_q >= FILT_CYC - 1);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_q <= 1'b0;
            hold_q <= 32'h0;
        end else begin
            last_q <= bus_dom_i;
            hold_q <= (bus_dom_i != last_q) ? 32'h0 : hold_q + 32'h1;
        end
    end

    // window runs from first filtered dominant; expiry discards
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q               <= WP_IDLE;
            win_q              <= 32'h0;
            bus_wake_pattern_o <= 1'b0;
        end else begin
            bus_wake_pattern_o <= 1'b0;
            if (st_q != WP_IDLE) begin
                win_q <= win_q + 32'h1;
            end
            if (!enable_i) begin
                st_q <= WP_IDLE;
            end else if (st_q != WP_IDLE && win_q >= WIN_CYC - 1) begin
                st_q <= WP_IDLE;
            end else begin
                case (st_q)
                    WP_IDLE: if (bus_dom_i && last_q && filt_ok) begin
                        st_q  <= WP_DOM1;
                        win_q <= 32'h0;
                    end
                    WP_DOM1: if (!bus_dom_i && !last_q && filt_ok) begin
                        st_q <= WP_REC;
                    end
                    WP_REC: if (bus_dom_i && last_q && filt_ok) begin
                        st_q <= WP_DOM2;
                    end
                    WP_DOM2: if (!bus_dom_i && !last_q && filt_ok) begin
                        st_q               <= WP_IDLE;
                        bus_wake_pattern_o <= 1'b1;
                    end
                    default: st_q <= WP_IDLE;
                endcase
            end
        end
    end
endmodule : wake_pattern_detect
`default_nettype wire

// ### design/dominant_guard.sv
`default_nettype none
module dominant_guard #(
    parameter int unsigned DTO_CYC = 100000
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic txd_i,
    input  wire logic drv_allow_i,
    output logic      drv_dom_o,
    output logic      dto_flag_o
);
    import can_mode_pkg::*;

    logic [31:0] cnt_q;

    // ------------------------------------------------------------
    // count dominant time; latch off until txd goes recessive
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q      <= 32'h0;
            dto_flag_o <= 1'b0;
        end else if (txd_i) begin
            cnt_q      <= 32'h0;
            dto_flag_o <= 1'b0;
        end else begin
            if (cnt_q < DTO_CYC) begin
                cnt_q <= cnt_q + 32'h1;
            end else begin
                dto_flag_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            drv_dom_o <= 1'b0;
        end else begin
            drv_dom_o <= drv_allow_i && !txd_i && !dto_flag_o
                         && !(cnt_q >= DTO_CYC);
        end
    end
endmodule : dominant_guard
`default_nettype wire

// ### design/can_mode_wake_timeouts.sv
// Notes on behaviour
// - standby to normal within 70 us
// - sleep command: inhibit, wake request off, 200 us
// - wake in sleep asserts both within 200 us
// - normal to standby within 200 us
// - each wake phase filtered by hold time
// - wake pattern valid only inside window
// - silence timer restarts on every bus edge
// - host must answer after wake, else sleep
// - long dominant transmit disables the driver
// - driver stays off until transmit recessive
`default_nettype none
module can_mode_wake_timeouts #(
    parameter int unsigned   WAKE_FILT_CYC = can_mode_pkg::WAKE_FILT_CYC,
    parameter int unsigned   WAKE_WIN_CYC  = can_mode_pkg::WAKE_WIN_CYC,
    parameter int unsigned   DTO_CYC       = can_mode_pkg::DOM_TIMEOUT_CYC,
    parameter longint unsigned SILENCE_CYC = can_mode_pkg::SILENCE_CYC,
    parameter longint unsigned INACTIVE_CYC = can_mode_pkg::INACTIVE_CYC,
    parameter int unsigned   STBY_NOM_CYC  = can_mode_pkg::STBY_NOM_CYC,
    parameter int unsigned   NOM_SLP_CYC   = can_mode_pkg::NOM_SLP_CYC,
    parameter int unsigned   SLP_STBY_CYC  = can_mode_pkg::SLP_STBY_CYC,
    parameter int unsigned   NOM_STBY_CYC  = can_mode_pkg::NOM_STBY_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               cmd_valid_i,
    input  wire logic [1:0]         cmd_mode_i,
    input  wire logic               wake_clear_i,
    input  wire logic               bus_rx_i,
    input  wire logic               local_wake_input_i,
    input  wire logic               txd_i,
    output can_mode_pkg::mode_t     mode_o,
    output logic                    mode_busy_o,
    output logic                    wake_flag_o,
    output logic                    supply_inhibit_out_o,
    output logic                    wake_request_out_n_o,
    output logic                    bus_silent_o,
    output logic                    drv_dom_o,
    output logic                    dto_flag_o
);
    import can_mode_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rx_s_q;
    logic [1:0] lw_s_q;
    logic       lw_last_q;
    logic       bus_dom;
    logic       lw_edge;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_s_q    <= 2'h3;
            lw_s_q    <= 2'h0;
            lw_last_q <= 1'b0;
        end else begin
            rx_s_q    <= {rx_s_q[0], bus_rx_i};
            lw_s_q    <= {lw_s_q[0], local_wake_input_i};
            lw_last_q <= lw_s_q[1];
        end
    end

    assign bus_dom = !rx_s_q[1];
    assign lw_edge = lw_s_q[1] && !lw_last_q;

    // ------------------------------------------------------------
    // wake pattern detection
    // ------------------------------------------------------------
    logic  pattern_pulse;
    mode_t mode_q;
    mode_t target_q;

    // detection runs in standby and sleep; normal mode ignores it
    wake_pattern_detect #(
        .FILT_CYC (WAKE_FILT_CYC),
        .WIN_CYC  (WAKE_WIN_CYC)
    ) u_wake_det (
        .clk_i              (clk_i),
        .arst_n_i           (arst_n_i),
        .enable_i           (mode_q != MODE_NORMAL),
        .bus_dom_i          (bus_dom),
        .bus_wake_pattern_o (pattern_pulse)
    );

    logic wake_evt;
    assign wake_evt = (mode_q == MODE_SLEEP) && (pattern_pulse || lw_edge);

    // ------------------------------------------------------------
    // bus silence timer
    // ------------------------------------------------------------
    logic        dom_last_q;
    logic [39:0] sil_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dom_last_q   <= 1'b0;
            sil_q        <= 40'h0;
            bus_silent_o <= 1'b0;
        end else begin
            dom_last_q <= bus_dom;
            if (bus_dom != dom_last_q) begin
                sil_q        <= 40'h0;
                bus_silent_o <= 1'b0;
            end else if (sil_q >= 40'(SILENCE_CYC - 1)) begin
                bus_silent_o <= 1'b1;
            end else begin
                sil_q <= sil_q + 40'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // wake flag and host inactivity timer
    // ------------------------------------------------------------
    logic [39:0] inact_q;
    logic        inact_run_q;
    logic        inact_exp;

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_flag_o <= 1'b1;
        end else if (wake_evt) begin
            wake_flag_o <= 1'b1;
        end else if (wake_clear_i) begin
            wake_flag_o <= 1'b0;
        end
    end

    // runs from reset and each wake until cleared or normal ordered
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            inact_run_q <= 1'b1;
            inact_q     <= 40'h0;
        end else if (wake_evt) begin
            inact_run_q <= 1'b1;
            inact_q     <= 40'h0;
        end else if (wake_clear_i || (cmd_valid_i && cmd_mode_i == CMD_NORMAL)) begin
            inact_run_q <= 1'b0;
            inact_q     <= 40'h0;
        end else if (inact_exp) begin
            inact_run_q <= 1'b0;
        end else if (inact_run_q) begin
            inact_q <= inact_q + 40'h1;
        end
    end

    assign inact_exp = inact_run_q && (inact_q >= 40'(INACTIVE_CYC - 1));

    // ------------------------------------------------------------
    // mode controller
    // ------------------------------------------------------------
    logic [31:0] dly_q;
    logic        busy_q;

    // transitions settle after a fixed delay below each maximum
    function automatic logic [31:0] trans_cyc(input mode_t from, input mode_t to);
        logic [31:0] c;
        c = 32'h1;
        if (from == MODE_STANDBY && to == MODE_NORMAL) begin
            c = 32'(STBY_NOM_CYC / 2);
        end else if (to == MODE_SLEEP) begin
            c = 32'(NOM_SLP_CYC / 2);
        end else if (from == MODE_SLEEP) begin
            c = 32'(SLP_STBY_CYC / 2);
        end else if (from == MODE_NORMAL && to == MODE_STANDBY) begin
            c = 32'(NOM_STBY_CYC / 2);
        end
        return c;
    endfunction : trans_cyc

    function automatic mode_t cmd_to_mode(input logic [1:0] c);
        case (c)
            CMD_SLEEP:   return MODE_SLEEP;
            CMD_NORMAL:  return MODE_NORMAL;
            default:     return MODE_STANDBY;
        endcase
    endfunction : cmd_to_mode

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q   <= MODE_STANDBY;
            target_q <= MODE_STANDBY;
            dly_q    <= 32'h0;
            busy_q   <= 1'b0;
        end else if (busy_q) begin
            if (dly_q <= 32'h1) begin
                mode_q <= target_q;
                busy_q <= 1'b0;
            end else begin
                dly_q <= dly_q - 32'h1;
            end
        end else if (wake_evt) begin
            target_q <= MODE_STANDBY;
            dly_q    <= trans_cyc(MODE_SLEEP, MODE_STANDBY);
            busy_q   <= 1'b1;
        end else if (inact_exp && mode_q != MODE_NORMAL) begin
            target_q <= MODE_SLEEP;
            dly_q    <= trans_cyc(mode_q, MODE_SLEEP);
            busy_q   <= 1'b1;
        end else if (cmd_valid_i && mode_q != MODE_SLEEP
                     && cmd_to_mode(cmd_mode_i) != mode_q) begin
            target_q <= cmd_to_mode(cmd_mode_i);
            dly_q    <= trans_cyc(mode_q, cmd_to_mode(cmd_mode_i));
            busy_q   <= 1'b1;
        end
    end

    assign mode_o      = mode_q;
    assign mode_busy_o = busy_q;

    // ------------------------------------------------------------
    // inhibit and wake request outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            supply_inhibit_out_o <= 1'b1;
            wake_request_out_n_o <= 1'b0;
        end else begin
            supply_inhibit_out_o <= (mode_q != MODE_SLEEP);
            wake_request_out_n_o <= (mode_q == MODE_SLEEP) || !wake_flag_o;
        end
    end

    // ------------------------------------------------------------
    // transmit path with dominant timeout
    // ------------------------------------------------------------
    // a slow host bit rate would trip this guard on legal frames
    dominant_guard #(
        .DTO_CYC (DTO_CYC)
    ) u_dto (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .txd_i       (txd_i),
        .drv_allow_i (mode_q == MODE_NORMAL),
        .drv_dom_o   (drv_dom_o),
        .dto_flag_o  (dto_flag_o)
    );
endmodule : can_mode_wake_timeouts
`default_nettype wire

// ### tb/can_mode_checker.sv
`default_nettype none
module can_mode_checker #(
    parameter int unsigned     DTO_CYC      = 200,
    parameter longint unsigned SILENCE_CYC  = 1000,
    parameter int unsigned     STBY_NOM_CYC = 20,
    parameter int unsigned     NOM_SLP_CYC  = 20,
    parameter int unsigned     SLP_STBY_CYC = 20,
    parameter int unsigned     NOM_STBY_CYC = 20
) (
    input wire logic                clk_i,
    input wire logic                arst_n_i,
    input wire logic                cmd_valid_i,
    input wire logic [1:0]          cmd_mode_i,
    input wire logic                bus_rx_i,
    input wire logic                txd_i,
    input wire can_mode_pkg::mode_t mode_o,
    input wire logic                mode_busy_o,
    input wire logic                wake_flag_o,
    input wire logic                supply_inhibit_out_o,
    input wire logic                wake_request_out_n_o,
    input wire logic                bus_silent_o,
    input wire logic                drv_dom_o,
    input wire logic                dto_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import can_mode_pkg::*;
    // --------------------------------------------------------
    // run counters; bounds carry sync and output register slack
    // --------------------------------------------------------
    localparam int              T_SN    = STBY_NOM_CYC + 2;
    localparam int              T_NS    = NOM_SLP_CYC + 3;
    localparam int              T_SS    = SLP_STBY_CYC + 3;
    localparam int              T_NB    = NOM_STBY_CYC + 2;
    localparam longint unsigned SIL_MAX = SILENCE_CYC + 4;
    logic [15:0]                low_q;
    logic [31:0]                quiet_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) low_q <= '0;
        else if (txd_i) low_q <= '0;
        else if (low_q != 16'hffff) low_q <= low_q + 16'h1;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) quiet_q <= '0;
        else if ($changed(bus_rx_i)) quiet_q <= '0;
        else if (quiet_q < SIL_MAX) quiet_q <= quiet_q + 32'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // --------------------------------------------------------
    // properties
    // --------------------------------------------------------
    a_stby_to_norm: assert property (cmd_valid_i && cmd_mode_i == CMD_NORMAL && !mode_busy_o
        && mode_o == MODE_STANDBY |-> ##[1:T_SN] mode_o == MODE_NORMAL)
        else $error("standby to normal too slow");
    a_sleep_cmd_off: assert property (cmd_valid_i && cmd_mode_i == CMD_SLEEP && !mode_busy_o
        && mode_o == MODE_NORMAL |-> ##[1:T_NS] !supply_inhibit_out_o && wake_request_out_n_o)
        else $error("sleep entry outputs too slow");
    a_wake_assert: assert property (mode_o == MODE_SLEEP && $rose(wake_flag_o)
        |-> ##[1:T_SS] supply_inhibit_out_o && !wake_request_out_n_o)
        else $error("wake outputs too slow");
    a_norm_to_stby: assert property (cmd_valid_i && cmd_mode_i == CMD_STANDBY && !mode_busy_o
        && mode_o == MODE_NORMAL |-> ##[1:T_NB] mode_o == MODE_STANDBY)
        else $error("normal to standby too slow");
    a_inhibit_mode: assert property (supply_inhibit_out_o == ($past(mode_o) != MODE_SLEEP))
        else $error("inhibit does not follow mode");
    a_wake_req_sleep: assert property ($past(mode_o) == MODE_SLEEP |-> wake_request_out_n_o)
        else $error("wake request active in sleep");
    a_silence_set: assert property (quiet_q == SIL_MAX |-> bus_silent_o)
        else $error("silence not flagged");
    a_silence_clr: assert property ($changed(bus_rx_i) |-> ##[1:5] !bus_silent_o)
        else $error("silence not restarted");
    a_dto_trip: assert property (low_q > DTO_CYC + 3 |-> dto_flag_o && !drv_dom_o)
        else $error("dominant timeout missed");
    a_dto_hold: assert property (dto_flag_o && !txd_i |=> !drv_dom_o)
        else $error("driver back on while transmit low");
    a_drv_cause: assert property (drv_dom_o |-> !$past(txd_i))
        else $error("driver dominant without transmit");
endmodule : can_mode_checker

bind can_mode_wake_timeouts can_mode_checker #(
    .DTO_CYC(DTO_CYC), .SILENCE_CYC(SILENCE_CYC), .STBY_NOM_CYC(STBY_NOM_CYC),
    .NOM_SLP_CYC(NOM_SLP_CYC), .SLP_STBY_CYC(SLP_STBY_CYC), .NOM_STBY_CYC(NOM_STBY_CYC)
) can_mode_checker_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_mode_i(cmd_mode_i),
    .bus_rx_i(bus_rx_i), .txd_i(txd_i), .mode_o(mode_o), .mode_busy_o(mode_busy_o),
    .wake_flag_o(wake_flag_o), .supply_inhibit_out_o(supply_inhibit_out_o),
    .wake_request_out_n_o(wake_request_out_n_o), .bus_silent_o(bus_silent_o),
    .drv_dom_o(drv_dom_o), .dto_flag_o(dto_flag_o)
);
`default_nettype wire

// ### tb/can_bus_node.sv
`default_nettype none
module can_bus_node (
    input  wire logic clk_i,
    output var logic  bus_rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------
    // far bus node; idles recessive, called on a falling edge
    // --------------------------------------------------------
    initial bus_rx_o = 1'b1;
    task automatic wake_pattern(input int len);
        for (int i = 0; i < 4; i++) begin
            bus_rx_o <= i[0];
            repeat (len) @(negedge clk_i);
        end
    endtask : wake_pattern
    task automatic blip(input int len);
        bus_rx_o <= 1'b0;
        repeat (len) @(negedge clk_i);
        bus_rx_o <= 1'b1;
    endtask : blip
endmodule : can_bus_node
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import can_mode_pkg::*;
    // --------------------------------------------------------
    // shortened counts keep the run under ten thousand cycles
    // --------------------------------------------------------
    localparam int T   = 20;
    localparam int DTO = 200;
    logic       clk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic       cmd_valid_i = 1'b0;
    logic [1:0] cmd_mode_i = 2'h1;
    logic       wake_clear_i = 1'b0;
    logic       local_wake_input_i = 1'b0;
    logic       txd_i = 1'b1;
    wire logic  bus_rx_i;
    mode_t      mode_o;
    logic       mode_busy_o, wake_flag_o, supply_inhibit_out_o, wake_request_out_n_o;
    logic       bus_silent_o, drv_dom_o, dto_flag_o;
    int         n_mismatch = 0;
    int         n_compared = 0;
    can_mode_wake_timeouts #(.WAKE_WIN_CYC(500), .DTO_CYC(DTO), .SILENCE_CYC(1000),
        .INACTIVE_CYC(2000), .STBY_NOM_CYC(T), .NOM_SLP_CYC(T), .SLP_STBY_CYC(T),
        .NOM_STBY_CYC(T)) can_mode_wake_timeouts_i (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_mode_i(cmd_mode_i), .wake_clear_i(wake_clear_i), .bus_rx_i(bus_rx_i),
        .local_wake_input_i(local_wake_input_i), .txd_i(txd_i), .mode_o(mode_o),
        .mode_busy_o(mode_busy_o), .wake_flag_o(wake_flag_o),
        .supply_inhibit_out_o(supply_inhibit_out_o),
        .wake_request_out_n_o(wake_request_out_n_o), .bus_silent_o(bus_silent_o),
        .drv_dom_o(drv_dom_o), .dto_flag_o(dto_flag_o));
    can_bus_node can_bus_node_i (.clk_i(clk_i), .bus_rx_o(bus_rx_i));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    function automatic int bound(input int n);
        return n + 2;  // n+1 edges plus the pulse cycle
    endfunction : bound
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic finish_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic cmd(input logic [1:0] m);
        cmd_valid_i = 1'b1;
        cmd_mode_i = m;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
    endtask : cmd
    task automatic host_clear;
        wake_clear_i = 1'b1;
        @(negedge clk_i);
        wake_clear_i = 1'b0;
    endtask : host_clear
    task automatic wait_sig(input int s, input logic [1:0] v, input int lim, output int n);
        logic hit;
        for (n = 0; n < lim; n++) begin
            @(negedge clk_i);
            case (s)
                0: hit = (mode_o === mode_t'(v));
                1: hit = (wake_flag_o === v[0]);
                2: hit = (supply_inhibit_out_o === v[0]);
                default: hit = (bus_silent_o === v[0]);
            endcase
            if (hit) return;
        end
        check("wait", 32'h1, 32'h0);
        finish_test();
    endtask : wait_sig
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        int n;
        int len;
        void'($urandom(32'h2d819fee));
        repeat (3) @(negedge clk_i);
        arst_n_i = 1'b1;
        check("mode_rst", MODE_STANDBY, mode_o);
        check("flag_rst", 1, wake_flag_o);
        host_clear();
        @(negedge clk_i);
        check("flag_clr", 0, wake_flag_o);
        cmd(CMD_NORMAL);
        wait_sig(0, MODE_NORMAL, 100, n);
        check("t_stby_norm", 1, n < bound(T));
        repeat (40) begin  // short bits, runs far below the timeout
            txd_i = 1'($urandom_range(1, 0));
            repeat ($urandom_range(10, 1)) @(negedge clk_i);
        end
        check("dto_idle", 0, dto_flag_o);
        txd_i = 1'b0;
        repeat (3) @(negedge clk_i);
        check("drv_on", 1, drv_dom_o);
        repeat (DTO + 5) @(negedge clk_i);
        check("dto_trip", 1, dto_flag_o);
        check("drv_off", 0, drv_dom_o);
        repeat (20) @(negedge clk_i);
        check("drv_held", 0, drv_dom_o);
        txd_i = 1'b1;
        repeat (2) @(negedge clk_i);
        txd_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check("drv_again", 1, drv_dom_o);
        txd_i = 1'b1;
        cmd(CMD_STANDBY);
        check("busy", 1, mode_busy_o);
        @(negedge clk_i);
        cmd(2'($urandom_range(3, 0))); // lands while busy, so ignored
        wait_sig(0, MODE_STANDBY, 100, n);
        check("t_norm_stby", 1, n < bound(T));
        repeat (T + 5) @(negedge clk_i);
        check("refused", MODE_STANDBY, mode_o);
        cmd(CMD_NORMAL);
        wait_sig(0, MODE_NORMAL, 100, n);
        cmd(CMD_SLEEP);
        wait_sig(2, 0, 100, n);
        check("t_nom_slp", 1, n < bound(T) + 1);
        check("wrq_slp", 1, wake_request_out_n_o);
        can_bus_node_i.wake_pattern(30);
        can_bus_node_i.wake_pattern(180);
        repeat (20) @(negedge clk_i);
        check("no_wake", MODE_SLEEP, mode_o);
        wait_sig(3, 1, 1200, n);
        can_bus_node_i.blip(10);
        wait_sig(3, 0, 8, n);
        repeat (600) @(negedge clk_i);
        len = $urandom_range(100, 60);
        fork
            can_bus_node_i.wake_pattern(len);
        join_none
        wait_sig(1, 1, 1000, n);
        wait_sig(2, 1, 50, n);
        check("t_wake_inh", 1, n < bound(T) + 2);
        check("wrq_wake", 0, wake_request_out_n_o);
        wait fork;
        wait_sig(0, MODE_SLEEP, 2500, n);
        check("inact_sleep", 1, n > 1500 && n < 2100);
        host_clear();
        check("flag_slp_clr", 0, wake_flag_o);
        local_wake_input_i = 1'b1;
        wait_sig(1, 1, 20, n);
        wait_sig(2, 1, 50, n);
        check("t_lwake", 1, n < bound(T) + 2);
        local_wake_input_i = 1'b0;
        host_clear();
        repeat (2200) @(negedge clk_i);
        check("host_kept", MODE_STANDBY, mode_o);
        check("flag_end", 0, wake_flag_o);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
